//--- common/sttmr_pkg.sv
package sttmr_pkg;

  localparam int          CLK_PERIOD_NS = 8;

  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_MODE      = 8'h04;
  localparam logic [7:0]  OFS_PERIOD    = 8'h08;
  localparam logic [7:0]  OFS_CMPA      = 8'h0C;
  localparam logic [7:0]  OFS_COUNT     = 8'h10;
  localparam logic [7:0]  OFS_FLAGS     = 8'h14;

  localparam int          BIT_ON        = 0;
  localparam int          BIT_FLAG_A    = 0;
  localparam int          BIT_FLAG_P    = 1;

  localparam logic [7:0]  RST_MODE      = 8'h00;
  localparam logic [7:0]  RST_PERIOD    = 8'h00;
  localparam logic [15:0] RST_CMPA      = 16'h0000;
  localparam logic [15:0] RST_COUNT     = 16'h0000;

  typedef enum logic [1:0] {
    SM_CMP   = 2'b00,
    SM_UNDEF = 2'b01,
    SM_PWM   = 2'b10,
    SM_TCNT  = 2'b11
  } sttmr_mode_t;

  typedef enum logic [1:0] {
    PF_HOLD   = 2'b00,
    PF_LOW    = 2'b01,
    PF_HIGH   = 2'b10,
    PF_TOGGLE = 2'b11
  } sttmr_pinfn_t;

  typedef struct packed {
    sttmr_mode_t  mode_select;
    sttmr_pinfn_t pin_function;
    logic         output_initial_level;
    logic         output_invert;
    logic         duty_period_swap;
    logic         clear_source_select;
  } sttmr_ctl_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sttmr_apb_req_t;

  typedef struct packed {
    logic        timer_on;
    logic        on_prev;
    sttmr_ctl_t  ctl;
    logic [7:0]  period;
    logic [15:0] cmpa;
    logic [15:0] count;
    logic        flag_a;
    logic        flag_p;
    logic        pin_state;
    logic        pin_out;
    logic        pin_oe;
    logic [31:0] rdata;
  } sttmr_state_t;

endpackage

//--- rtl/sttmr_core.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module sttmr_core
  import sttmr_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire sttmr_apb_req_t apb_req,
  output logic                pready,
  output logic                pslverr,
  output logic [31:0]         prdata,
  output logic                timer_output_pin,
  output logic                timer_output_pin_oe,
  output logic [15:0]         timer_count,
  output logic                match_a_flag,
  output logic                match_p_flag,
  output logic                timer_on
);

  sttmr_state_t q_ff;
  sttmr_state_t nxt_q;

  // Period comparator: true on the last count of a period of rp*256 (65536 when rp is 0)
  function automatic logic sttmr_p_end(input logic [15:0] cnt, input logic [7:0] rp);
    logic [7:0] top_next;
    top_next = cnt[15:8] + 8'h01;
    return (cnt[7:0] == 8'hFF) && (top_next == rp);
  endfunction

  function automatic logic sttmr_mapped(input logic [7:0] adr);
    return (adr == OFS_CTRL) || (adr == OFS_MODE) || (adr == OFS_PERIOD) ||
           (adr == OFS_CMPA) || (adr == OFS_COUNT) || (adr == OFS_FLAGS);
  endfunction

  logic        on_rise;
  logic        tick;
  logic        a_hit;
  logic        p_hit;
  logic        a_nonzero;
  logic        pulse_mode;
  logic        cmp_like;
  logic        clear_cnt;
  logic        set_a;
  logic        set_p;
  logic        pwm_active;
  logic        level;
  logic        wr_en;
  logic [31:0] rd_mux;

  always_comb begin
    on_rise    = q_ff.timer_on & ~q_ff.on_prev;
    tick       = q_ff.timer_on & ~on_rise;
    a_nonzero  = (q_ff.cmpa != 16'h0000);
    a_hit      = tick && (q_ff.count == q_ff.cmpa);
    p_hit      = tick && sttmr_p_end(q_ff.count, q_ff.period);
    pulse_mode = (q_ff.ctl.mode_select == SM_PWM) && (q_ff.ctl.pin_function == PF_TOGGLE);
    cmp_like   = (q_ff.ctl.mode_select != SM_PWM);
    clear_cnt  = 1'b0;
    set_a      = 1'b0;
    set_p      = 1'b0;
    if (cmp_like) begin
      if (q_ff.ctl.clear_source_select) begin
        clear_cnt = a_hit && a_nonzero;
        set_a     = a_hit && a_nonzero;
      end else begin
        clear_cnt = p_hit;
        set_a     = a_hit && a_nonzero;
        set_p     = p_hit;
      end
    end else if (pulse_mode) begin
      set_a = a_hit;
    end else begin
      clear_cnt = q_ff.ctl.duty_period_swap ? a_hit : p_hit;
      set_a     = a_hit;
      set_p     = p_hit;
    end
  end

  always_comb begin
    if (q_ff.ctl.duty_period_swap) begin
      pwm_active = (q_ff.period == 8'h00) || (q_ff.count < {q_ff.period, 8'h00});
    end else begin
      pwm_active = (q_ff.count < q_ff.cmpa);
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (apb_req.paddr)
      OFS_CTRL:   rd_mux[BIT_ON] = q_ff.timer_on;
      OFS_MODE:   rd_mux[7:0] = q_ff.ctl;
      OFS_PERIOD: rd_mux[7:0] = q_ff.period;
      OFS_CMPA:   rd_mux[15:0] = q_ff.cmpa;
      OFS_COUNT:  rd_mux[15:0] = q_ff.count;
      OFS_FLAGS:  rd_mux[1:0] = {q_ff.flag_p, q_ff.flag_a};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    nxt_q  = q_ff;
    wr_en  = apb_req.psel && apb_req.penable && apb_req.pwrite && sttmr_mapped(apb_req.paddr);
    if (apb_req.psel && !apb_req.penable) begin
      nxt_q.rdata = rd_mux;
    end
    nxt_q.on_prev = q_ff.timer_on;

    if (on_rise) begin
      nxt_q.count = RST_COUNT;
    end else if (tick && !pulse_mode && clear_cnt) begin
      nxt_q.count = RST_COUNT;
    end else if (tick && !(pulse_mode && a_hit)) begin
      nxt_q.count = q_ff.count + 16'h0001;
    end

    if (pulse_mode && a_hit) begin
      nxt_q.timer_on = 1'b0;
    end

    if (on_rise) begin
      nxt_q.pin_state = q_ff.ctl.output_initial_level;
    end else if (q_ff.ctl.mode_select == SM_CMP && set_a) begin
      unique case (q_ff.ctl.pin_function)
        PF_HOLD:   nxt_q.pin_state = q_ff.pin_state;
        PF_LOW:    nxt_q.pin_state = 1'b0;
        PF_HIGH:   nxt_q.pin_state = 1'b1;
        PF_TOGGLE: nxt_q.pin_state = ~q_ff.pin_state;
      endcase
    end

    unique case (q_ff.ctl.mode_select)
      SM_CMP: level = q_ff.pin_state;
      SM_PWM: begin
        unique case (q_ff.ctl.pin_function)
          PF_HOLD:   level = ~q_ff.ctl.output_initial_level;
          PF_LOW:    level = q_ff.ctl.output_initial_level;
          PF_HIGH:   level = pwm_active ? q_ff.ctl.output_initial_level : ~q_ff.ctl.output_initial_level;
          PF_TOGGLE: level = q_ff.timer_on ? q_ff.ctl.output_initial_level : ~q_ff.ctl.output_initial_level;
        endcase
      end
      default: level = 1'b0;
    endcase
    if (q_ff.ctl.mode_select == SM_CMP || q_ff.ctl.mode_select == SM_PWM) begin
      nxt_q.pin_out = level ^ q_ff.ctl.output_invert;
      nxt_q.pin_oe  = 1'b1;
    end else begin
      nxt_q.pin_out = 1'b0;
      nxt_q.pin_oe  = 1'b0;
    end

    nxt_q.flag_a = q_ff.flag_a | set_a;
    nxt_q.flag_p = q_ff.flag_p | set_p;

    if (wr_en) begin
      unique case (apb_req.paddr)
        OFS_CTRL:   nxt_q.timer_on = apb_req.pwdata[BIT_ON];
        OFS_MODE:   nxt_q.ctl = sttmr_ctl_t'(apb_req.pwdata[7:0]);
        OFS_PERIOD: nxt_q.period = apb_req.pwdata[7:0];
        OFS_CMPA:   nxt_q.cmpa = apb_req.pwdata[15:0];
        OFS_FLAGS: begin
          nxt_q.flag_a = (q_ff.flag_a & ~apb_req.pwdata[BIT_FLAG_A]) | set_a;
          nxt_q.flag_p = (q_ff.flag_p & ~apb_req.pwdata[BIT_FLAG_P]) | set_p;
        end
        default: nxt_q.cmpa = q_ff.cmpa;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff <= '{timer_on: 1'b0, on_prev: 1'b0, ctl: sttmr_ctl_t'(RST_MODE), period: RST_PERIOD,
                cmpa: RST_CMPA, count: RST_COUNT, flag_a: 1'b0, flag_p: 1'b0,
                pin_state: 1'b0, pin_out: 1'b0, pin_oe: 1'b0, rdata: 32'h0000_0000};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign pready              = apb_req.psel && apb_req.penable;
  assign pslverr             = apb_req.psel && apb_req.penable && !sttmr_mapped(apb_req.paddr);
  assign prdata              = q_ff.rdata;
  assign timer_output_pin    = q_ff.pin_out;
  assign timer_output_pin_oe = q_ff.pin_oe;
  assign timer_count         = q_ff.count;
  assign match_a_flag        = q_ff.flag_a;
  assign match_p_flag        = q_ff.flag_p;
  assign timer_on            = q_ff.timer_on;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  count_restart_a: assert property (q_ff.timer_on && !q_ff.on_prev |=> q_ff.count == 16'h0000)
    else $error("counter not zeroed after on rise");
  count_hold_a: assert property (!q_ff.timer_on && !$past(wr_en) |=> $stable(q_ff.count))
    else $error("counter moved while off");
  init_level_a: assert property (q_ff.timer_on && !q_ff.on_prev |=> q_ff.pin_state == $past(q_ff.ctl.output_initial_level))
    else $error("pin not restored to initial level");
  cmp_toggle_a: assert property (q_ff.ctl.mode_select == SM_CMP && q_ff.ctl.pin_function == PF_TOGGLE && set_a && !on_rise
                                 |=> q_ff.pin_state != $past(q_ff.pin_state))
    else $error("toggle missed on match A");
  p_no_pin_a: assert property (q_ff.ctl.mode_select == SM_CMP && !set_a && !on_rise |=> $stable(q_ff.pin_state))
    else $error("pin changed without match A");
  no_flag_p_a: assert property (cmp_like && q_ff.ctl.clear_source_select |-> !set_p)
    else $error("flag P raised with clear source A");
  zero_a_flag_a: assert property (cmp_like && q_ff.cmpa == 16'h0000 |-> !set_a)
    else $error("flag A raised with compare A zero");
  p_clear_a: assert property (cmp_like && !q_ff.ctl.clear_source_select && p_hit |=> q_ff.count == 16'h0000
                              ##1 q_ff.timer_on |-> q_ff.count == 16'h0001)
    else $error("period match did not clear counter");
  counter_pin_a: assert property (q_ff.ctl.mode_select == SM_TCNT |=> !timer_output_pin_oe)
    else $error("pin driven in counter mode");
  flag_set_win_a: assert property (set_a |=> match_a_flag)
    else $error("flag A lost against clear");

  // Flag checks
  flag_a_keep_a: assert property (q_ff.flag_a && !(wr_en && apb_req.paddr == OFS_FLAGS)
                                  |=> match_a_flag)
    else $error("flag A dropped without clear");

  flag_p_keep_a: assert property (q_ff.flag_p && !(wr_en && apb_req.paddr == OFS_FLAGS)
                                  |=> match_p_flag)
    else $error("flag P dropped without clear");

  flag_p_set_a: assert property (set_p
                                 |=> match_p_flag)
    else $error("flag P lost against clear");

  cmp_flag_p_a: assert property (q_ff.ctl.mode_select == SM_CMP && !q_ff.ctl.clear_source_select && p_hit
                                 |-> set_p)
    else $error("period match raised no flag P");

  // Counter checks
  a_clear_a: assert property (cmp_like && q_ff.ctl.clear_source_select && a_hit && a_nonzero
                              |=> q_ff.count == 16'h0000)
    else $error("match A did not clear counter");

  count_step_a: assert property (tick && !clear_cnt && !(pulse_mode && a_hit)
                                 |=> q_ff.count == $past(q_ff.count) + 16'h0001)
    else $error("counter did not advance by one");

  p_top_byte_a: assert property (p_hit
                                 |-> q_ff.count == {q_ff.period - 8'h01, 8'hFF})
    else $error("period match off its top byte");

  ovf_wrap_a: assert property (cmp_like && !q_ff.ctl.clear_source_select && q_ff.period == 8'h00 && tick
                               && q_ff.count == 16'hFFFF |-> p_hit)
    else $error("no overflow clear with period zero");

  no_ovf_clr_a: assert property (cmp_like && q_ff.period != 8'h00 && tick && q_ff.count == 16'hFFFF
                                 |-> !p_hit)
    else $error("overflow match with period nonzero");

  pwm_a_clear_a: assert property (q_ff.ctl.mode_select == SM_PWM && !pulse_mode && q_ff.ctl.duty_period_swap
                                  && a_hit |=> q_ff.count == 16'h0000)
    else $error("swapped PWM period not from A");

  pwm_p_clear_a: assert property (q_ff.ctl.mode_select == SM_PWM && !pulse_mode && !q_ff.ctl.duty_period_swap
                                  && p_hit |=> q_ff.count == 16'h0000)
    else $error("PWM period not from P");

  pulse_stop_a: assert property (pulse_mode && a_hit && !wr_en
                                 |=> !q_ff.timer_on)
    else $error("pulse did not end on match A");

  pulse_hold_a: assert property (pulse_mode && a_hit
                                 |=> $stable(q_ff.count))
    else $error("counter moved after pulse end");

  // Pin checks
  cmp_oe_a: assert property (q_ff.ctl.mode_select == SM_CMP
                             |=> timer_output_pin_oe)
    else $error("pin not driven in compare mode");

  cmp_invert_a: assert property (q_ff.ctl.mode_select == SM_CMP
                                 |=> timer_output_pin == $past(q_ff.pin_state ^ q_ff.ctl.output_invert))
    else $error("compare pin polarity wrong");

  cmp_low_a: assert property (q_ff.ctl.mode_select == SM_CMP && q_ff.ctl.pin_function == PF_LOW && set_a
                              |=> !q_ff.pin_state)
    else $error("pin not low after match A");

  cmp_high_a: assert property (q_ff.ctl.mode_select == SM_CMP && q_ff.ctl.pin_function == PF_HIGH && set_a
                               |=> q_ff.pin_state)
    else $error("pin not high after match A");

  cmp_hold_a: assert property (q_ff.ctl.mode_select == SM_CMP && q_ff.ctl.pin_function == PF_HOLD && set_a
                               |=> $stable(q_ff.pin_state))
    else $error("pin changed with no-change function");

  pwm_idle_a: assert property (q_ff.ctl.mode_select == SM_PWM && q_ff.ctl.pin_function == PF_HOLD
                               |=> timer_output_pin == $past(~q_ff.ctl.output_initial_level ^ q_ff.ctl.output_invert))
    else $error("forced inactive level wrong");

  pwm_force_a: assert property (q_ff.ctl.mode_select == SM_PWM && q_ff.ctl.pin_function == PF_LOW
                                |=> timer_output_pin == $past(q_ff.ctl.output_initial_level ^ q_ff.ctl.output_invert))
    else $error("forced active level wrong");

  undef_pin_a: assert property (q_ff.ctl.mode_select == SM_UNDEF
                                |=> !timer_output_pin_oe)
    else $error("pin driven in undefined mode");

  // Bus checks
  unmapped_rd_a: assert property (apb_req.psel && !apb_req.penable && !sttmr_mapped(apb_req.paddr)
                                  |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");

endmodule

`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import sttmr_pkg::*;
;
  logic           clk;
  logic           rst_n;
  sttmr_apb_req_t req;
  logic           pready;
  logic           pslverr;
  logic [31:0]    prdata;
  logic           pin;
  logic           pin_oe;
  logic [15:0]    timer_count;
  logic           flag_a;
  logic           flag_p;
  logic           tmr_on;
  logic [31:0]    rd;
  logic           err;
  int             n;
  int             n_fail;
  int             n_tests;

  sttmr_core dut (.clk(clk), .rst_n(rst_n), .apb_req(req), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .timer_output_pin(pin), .timer_output_pin_oe(pin_oe), .timer_count(timer_count),
    .match_a_flag(flag_a), .match_p_flag(flag_p), .timer_on(tmr_on));

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic finish_test;
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) chk("pready", 32'h0000_0001, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Counts edges until the counter shows v
  task automatic wait_cnt(input logic [15:0] v);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (timer_count !== v && n < 70000);
    if (n >= 70000) chk("count wait", {16'h0000, v}, {16'h0000, timer_count});
  endtask

  task automatic start(input logic [7:0] m, input logic [7:0] p, input logic [15:0] a);
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b1, OFS_MODE, {24'h000000, m});
    apb(1'b1, OFS_PERIOD, {24'h000000, p});
    apb(1'b1, OFS_CMPA, {16'h0000, a});
    apb(1'b1, OFS_FLAGS, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clk);
  endtask

  task automatic pin_at(input logic [15:0] c, input logic e);
    wait_cnt(c);
    chk("pin", {31'h0, e}, {31'h0, pin});
  endtask

  task automatic pwm(input logic [7:0] m, input logic [15:0] a, input logic [15:0] c1, input logic e1,
                     input logic [15:0] c2, input logic e2);
    start(m, 8'h01, a);
    pin_at(c1, e1);
    pin_at(c2, e2);
  endtask

  task automatic t_regs;
    logic [7:0] ofs [6];
    ofs = '{OFS_CTRL, OFS_MODE, OFS_PERIOD, OFS_CMPA, OFS_COUNT, OFS_FLAGS};
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0000_0000);
      chk("reset value", 32'h0000_0000, rd);
    end
    apb(1'b1, OFS_PERIOD, 32'hFFFF_FFA5);
    apb(1'b0, OFS_PERIOD, 32'h0000_0000);
    chk("period reg", 32'h0000_00A5, rd);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
  endtask

  task automatic t_cmp;
    logic [1:0] fn;
    logic       ini;
    logic       inv;
    logic       aft;
    for (int i = 0; i < 16; i++) begin
      fn = i[1:0];
      inv = i[2];
      ini = i[3];
      aft = (fn == 2'b00) ? ini : (fn == 2'b01) ? 1'b0 : (fn == 2'b10) ? 1'b1 : ~ini;
      start({2'b00, fn, ini, inv, 2'b00}, 8'h01, 16'h0010);
      pin_at(16'h0004, ini ^ inv);
      pin_at(16'h0080, aft ^ inv);
      chk("flag a", 32'h0000_0001, {31'h0, flag_a});
      chk("flag p", 32'h0000_0000, {31'h0, flag_p});
      wait_cnt(16'h0004);
      chk("edges to wrap", 32'h0000_0084, n);
      chk("flag p", 32'h0000_0001, {31'h0, flag_p});
      chk("pin", {31'h0, aft ^ inv}, {31'h0, pin});
      chk("pin oe", 32'h0000_0001, {31'h0, pin_oe});
    end
  endtask

  task automatic t_off;
    logic [31:0] first;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    apb(1'b0, OFS_COUNT, 32'h0000_0000);
    first = rd;
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_COUNT, 32'h0000_0000);
    chk("held count", first, rd);
    chk("count port", first, {16'h0000, timer_count});
  endtask

  task automatic t_clr1;
    start(8'h01, 8'h01, 16'h0300);
    wait_cnt(16'h0005);
    wait_cnt(16'h0005);
    chk("edges to clear", 32'h0000_0301, n);
    chk("flag p", 32'h0000_0000, {31'h0, flag_p});
    chk("flag a", 32'h0000_0001, {31'h0, flag_a});
  endtask

  task automatic t_tcnt;
    start(8'hF0, 8'h01, 16'h0010);
    wait_cnt(16'h0080);
    chk("pin oe", 32'h0000_0000, {31'h0, pin_oe});
    chk("flag a", 32'h0000_0001, {31'h0, flag_a});
  endtask

  task automatic t_pulse;
    start(8'hB8, 8'h01, 16'h0040);
    pin_at(16'h0020, 1'b1);
    chk("on bit", 32'h0000_0001, {31'h0, tmr_on});
    wait_cnt(16'h0040);
    repeat (3) @(negedge clk);
    chk("on bit", 32'h0000_0000, {31'h0, tmr_on});
    chk("pin", 32'h0000_0000, {31'h0, pin});
    chk("count", 32'h0000_0040, {16'h0000, timer_count});
    chk("flag a", 32'h0000_0001, {31'h0, flag_a});
  endtask

  task automatic t_ovf;
    start(8'h00, 8'h00, 16'h0000);
    wait_cnt(16'h0005);
    wait_cnt(16'h0005);
    chk("edges to wrap", 32'h0001_0000, n);
    chk("flag a", 32'h0000_0000, {31'h0, flag_a});
    chk("flag p", 32'h0000_0001, {31'h0, flag_p});
  endtask

  initial begin
    req = '0;
    rst_n = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_cmp;
    t_off;
    t_clr1;
    t_tcnt;
    pwm(8'hA8, 16'h0040, 16'h0020, 1'b1, 16'h0080, 1'b0);
    pwm(8'hA0, 16'h0040, 16'h0020, 1'b0, 16'h0080, 1'b1);
    pwm(8'hAC, 16'h0040, 16'h0020, 1'b0, 16'h0080, 1'b1);
    pwm(8'hAA, 16'h0200, 16'h0080, 1'b1, 16'h0180, 1'b0);
    pwm(8'hA9, 16'h0040, 16'h0020, 1'b1, 16'h0080, 1'b0);
    pwm(8'h88, 16'h0040, 16'h0020, 1'b0, 16'h0080, 1'b0);
    pwm(8'h98, 16'h0040, 16'h0020, 1'b1, 16'h0080, 1'b1);
    t_pulse;
    t_ovf;
    finish_test;
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
